// ==== pkg/csm_map.svh ====
// csm_map.svh: dword offsets, field positions, reset values, timing counts
// assumes: included by bare name from the bank module and the bench
`ifndef CSM_MAP_SVH
`define CSM_MAP_SVH
// dword indexes inside one function's configuration space
`define CSM_DW_ID 6'h00
`define CSM_DW_CMD 6'h01
`define CSM_DW_CLASS 6'h02
`define CSM_DW_HDR 6'h03
`define CSM_DW_BUSNUM 6'h06
`define CSM_DW_MISC 6'h10
`define CSM_DW_LOCK 6'h11
`define CSM_DW_ERRLOG 6'h12
// read-only contents
`define CSM_CLASS_HOST 32'h06000000
`define CSM_CLASS_P2P 32'h06040000
`define CSM_CLASS_ERR 32'hff000000
`define CSM_HDR_HOST 32'h00800000
`define CSM_HDR_P2P 32'h00810000
`define CSM_HDR_ERR 32'h00000000
// reset values and answers
`define CSM_RST_CMD 16'h0000
`define CSM_RST_BUSNUM 24'h000000
`define CSM_RST_LOCK 8'h00
`define CSM_RST_ERRLOG 32'h00000000
`define CSM_RST_MISC 32'h00000000
`define CSM_ALL_ONES 32'hffffffff
`define CSM_RSVD_READ 32'h00000000
// error log fields: first event and overflow
`define CSM_ERR_FIRST 0
`define CSM_ERR_OVER 1
// cycles from reset release until straps are taken
`define CSM_STRAP_WAIT 2'h2
`endif

// ==== pkg/csm_pkg.sv ====
// csm_pkg: request and answer carriers of the configuration bank
// assumes: csm_map.svh on the include path
`default_nettype none
package csm_pkg;
    // one configuration access from the host side
    typedef struct packed {
        logic wr;
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] fn;
        logic [5:0] dw;
        logic [3:0] be;
        logic [31:0] wdata;
    } csm_req_type;
    // registered answer, one cycle after the request
    typedef struct packed {
        logic [31:0] rdata;
        logic hit;
        logic abort;
    } csm_rsp_type;
endpackage
`default_nettype wire

// ==== logic/csm_bank.sv ====
// csm_bank: internal configuration devices of the host bridge on bus 0
// assumes: requests arrive on clk_i from decode logic; straps and soft reset
// are pins and are synchronised here; power good is used directly
//
// Operation
// - writing one clears a write-one-clear bit; writing zero leaves it
// - a lock bit takes its first write after power-up, then is read-only
// - error log survives soft and system reset; cleared only by power reset
// - full reset loads defaults; some defaults come from sampled straps
// - reserved locations are not written by software; reads may be nonzero
// - defaults give a minimal working set; software programs the rest
// - all internal functions live on bus 0 only
// - each wide hub port shows as a bridge with bus number registers
// - expansion bus is not bus 0; such accesses are not claimed here
// - device 0 decodes function 0 host controller and 1 reliability
// - device 0 function 0 holds header, memory and hub link registers
// - devices 2, 3, 4 decode bridge function 0 and error function 1
// - writes to read-only registers change nothing
// - power good resets everything; system reset resets non-sticky logic
// - disabled hub port: reads give all ones, writes master abort
`include "csm_map.svh"
`default_nettype none
module csm_bank #(
    parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
    parameter logic [15:0] DEVICE_BASE = 16'h0a00, // arbitrary value
    parameter int STRAP_W = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic supply_valid_reset_in_i,
    input wire logic soft_reset_i,
    input wire logic [STRAP_W-1:0] strap_i,
    input wire logic req_valid_i,
    input wire csm_pkg::csm_req_type req_i,
    input wire logic [7:0] err_set_i,
    output logic rsp_valid_o,
    output csm_pkg::csm_rsp_type rsp_o,
    output logic [2:0] port_en_o
);
    // power good clears all; system reset joins it for non-sticky state
    logic rst_n;
    assign rst_n = resetn_i & supply_valid_reset_in_i;

    // expand byte enables to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // device/function to index: 0,1 device 0; 2..7 bridges and error fns
    function automatic logic [3:0] fn_decode(input logic [4:0] dev,
                                             input logic [2:0] fn);
        fn_decode = 4'h0;
        if (fn[2:1] == 2'b00) begin
            case (dev)
                5'h00: fn_decode = {1'b1, 2'b00, fn[0]};
                5'h02: fn_decode = {1'b1, 2'b01, fn[0]};
                5'h03: fn_decode = {1'b1, 2'b10, fn[0]};
                5'h04: fn_decode = {1'b1, 2'b11, fn[0]};
                default: fn_decode = 4'h0;
            endcase
        end
    endfunction

    // ---- pin synchronisers and strap capture ----
    logic [STRAP_W-1:0] strap_m_q, strap_s_q, strap_q, strap_d;
    logic soft_m_q, soft_q;
    logic [1:0] wait_q, wait_d;
    logic strap_take;
    always_comb begin
        wait_d = wait_q;
        strap_d = strap_q;
        strap_take = (wait_q == `CSM_STRAP_WAIT);
        if (wait_q != 2'h3) begin
            wait_d = wait_q + 2'h1;
        end
        if (strap_take) begin
            strap_d = strap_s_q;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_m_q <= '0;
            strap_s_q <= '0;
            strap_q <= '0;
            soft_m_q <= 1'b0;
            soft_q <= 1'b0;
            wait_q <= 2'h0;
        end else begin
            strap_m_q <= strap_i;
            strap_s_q <= strap_m_q;
            strap_q <= strap_d;
            soft_m_q <= soft_reset_i;
            soft_q <= soft_m_q;
            wait_q <= wait_d;
        end
    end
    // low strap bits enable the three wide hub ports; zero until taken
    assign port_en_o = strap_q[2:0];

    // ---- request decode ----
    logic [3:0] dec;
    logic [2:0] idx;
    logic on_bus0, claim, port_off, acc, wr_acc;
    logic [3:0] en_map;
    logic [31:0] wm;
    always_comb begin
        dec = fn_decode(req_i.dev, req_i.fn);
        idx = dec[2:0];
        on_bus0 = (req_i.bus == 8'h00);
        claim = req_valid_i & on_bus0 & dec[3];
        // device 0 is always present, so its enable slot is tied high
        en_map = {port_en_o, 1'b1};
        port_off = ~en_map[idx[2:1]];
        acc = claim & ~port_off;
        wr_acc = acc & req_i.wr;
        wm = lane_mask(req_i.be);
    end

    // ---- non-sticky registers ----
    logic [7:0][15:0] cmd_q, cmd_d;
    logic [7:0][23:0] bus_q, bus_d;
    logic [31:0] misc_q, misc_d;
    always_comb begin
        cmd_d = cmd_q;
        bus_d = bus_q;
        misc_d = misc_q;
        if (strap_take) begin
            misc_d = 32'(strap_s_q);
        end
        if (wr_acc) begin
            case (req_i.dw)
                `CSM_DW_CMD: cmd_d[idx] = (cmd_q[idx] & ~wm[15:0])
                    | (req_i.wdata[15:0] & wm[15:0]);
                `CSM_DW_BUSNUM: if (idx[0] == 1'b0 && idx != 3'h0) begin
                    bus_d[idx] = (bus_q[idx] & ~wm[23:0])
                        | (req_i.wdata[23:0] & wm[23:0]);
                end
                `CSM_DW_MISC: if (idx == 3'h0) begin
                    misc_d = (misc_q & ~wm) | (req_i.wdata & wm);
                end
                default: misc_d = misc_d; // read-only, reserved, or sticky lock and error log written below
            endcase
        end
        if (soft_q) begin
            cmd_d = '0; // soft reset clears only non-sticky state
            bus_d = '0;
            misc_d = 32'(strap_q);
        end
    end
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= {8{`CSM_RST_CMD}};
            bus_q <= {8{`CSM_RST_BUSNUM}};
            misc_q <= `CSM_RST_MISC;
        end else begin
            cmd_q <= cmd_d;
            bus_q <= bus_d;
            misc_q <= misc_d;
        end
    end

    // ---- sticky registers: error log and lock, power good only ----
    logic [7:0][31:0] err_q, err_d;
    logic [7:0][7:0] lock_q, lock_d, lkw_q, lkw_d;
    logic [7:0] lock_cur;
    always_comb begin
        err_d = err_q;
        lock_d = lock_q;
        lkw_d = lkw_q;
        lock_cur = lock_q[idx];
        if (wr_acc && req_i.dw == `CSM_DW_ERRLOG) begin
            err_d[idx] = err_q[idx] & ~(req_i.wdata & wm);
        end
        if (wr_acc && req_i.dw == `CSM_DW_LOCK) begin
            // each open bit in an enabled lane takes its one write
            lock_d[idx] = (lock_q[idx] & (lkw_q[idx] | ~wm[7:0]))
                | (req_i.wdata[7:0] & wm[7:0] & ~lkw_q[idx]);
            lkw_d[idx] = lkw_q[idx] | wm[7:0];
        end
        // events applied last so a set wins over a same-cycle clear
        for (int f = 0; f < 8; f++) begin
            if (err_set_i[f]) begin
                // a clear of the overflow bit stands unless this event
                // itself overflows
                err_d[f][`CSM_ERR_OVER] = err_d[f][`CSM_ERR_OVER]
                    | err_q[f][`CSM_ERR_FIRST];
                err_d[f][`CSM_ERR_FIRST] = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_i or negedge supply_valid_reset_in_i) begin
        if (!supply_valid_reset_in_i) begin
            err_q <= {8{`CSM_RST_ERRLOG}};
            lock_q <= {8{`CSM_RST_LOCK}};
            lkw_q <= '0;
        end else begin
            err_q <= err_d;
            lock_q <= lock_d;
            lkw_q <= lkw_d;
        end
    end

    // ---- read mux and registered answer ----
    csm_pkg::csm_rsp_type rsp_q, rsp_d;
    logic rsp_valid_q;
    always_comb begin
        rsp_d.hit = acc;
        rsp_d.abort = claim & port_off & req_i.wr;
        rsp_d.rdata = `CSM_ALL_ONES; // unclaimed or disabled reads
        if (acc) begin
            case (req_i.dw)
                `CSM_DW_ID: rsp_d.rdata = {DEVICE_BASE + 16'(idx), VENDOR_ID};
                `CSM_DW_CMD: rsp_d.rdata = {16'h0000, cmd_q[idx]};
                `CSM_DW_CLASS: rsp_d.rdata = (idx == 3'h0) ? `CSM_CLASS_HOST
                    : idx[0] ? `CSM_CLASS_ERR : `CSM_CLASS_P2P;
                `CSM_DW_HDR: rsp_d.rdata = (idx == 3'h0) ? `CSM_HDR_HOST
                    : idx[0] ? `CSM_HDR_ERR : `CSM_HDR_P2P;
                `CSM_DW_BUSNUM: rsp_d.rdata = (idx[0] || idx == 3'h0)
                    ? `CSM_RSVD_READ : {8'h00, bus_q[idx]};
                `CSM_DW_MISC: rsp_d.rdata = (idx == 3'h0) ? misc_q
                    : `CSM_RSVD_READ;
                `CSM_DW_LOCK: rsp_d.rdata = {24'h000000, lock_q[idx]};
                `CSM_DW_ERRLOG: rsp_d.rdata = err_q[idx];
                default: rsp_d.rdata = `CSM_RSVD_READ;
            endcase
        end
    end
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
        end else begin
            rsp_valid_q <= req_valid_i;
            rsp_q <= rsp_d;
        end
    end
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_o = rsp_q;

    // ---- checks ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);
    w1c_clear_a: assert property (wr_acc && req_i.dw == `CSM_DW_ERRLOG
        && req_i.wdata[0] && req_i.be[0] && !err_set_i[idx]
        |=> !err_q[$past(idx)][0]) else $error("w1c bit not cleared");
    lock_once_a: assert property (wr_acc && req_i.dw == `CSM_DW_LOCK
        && lkw_q[idx] == 8'hff |=> lock_q[$past(idx)] == $past(lock_cur))
        else $error("locked bits changed");
    sticky_keep_a: assert property (soft_q && !req_valid_i
        && err_set_i == 8'h00 |=> $stable(err_q))
        else $error("sticky log lost on soft reset");
    strap_load_a: assert property (strap_take && !soft_q
        && !(wr_acc && req_i.dw == `CSM_DW_MISC)
        |=> misc_q == 32'($past(strap_s_q))) else $error("strap not loaded");
    off_read_a: assert property (claim && port_off && !req_i.wr
        |=> rsp_valid_o && rsp_o.rdata == `CSM_ALL_ONES && !rsp_o.hit)
        else $error("disabled port read not all ones");
    off_write_a: assert property (claim && port_off && req_i.wr
        |=> rsp_valid_o && rsp_o.abort && !rsp_o.hit)
        else $error("disabled port write not aborted");
    bus_zero_a: assert property (req_valid_i && req_i.bus != 8'h00
        |=> !rsp_o.hit && !rsp_o.abort) else $error("non-zero bus claimed");
    bad_fn_a: assert property (req_valid_i && req_i.fn > 3'h1
        |=> !rsp_o.hit) else $error("function above 1 claimed");
    soft_clr_a: assert property (soft_q |=> cmd_q == '0)
        else $error("soft reset left command set");
    lane_keep_a: assert property (wr_acc && req_i.dw == `CSM_DW_CMD
        && req_i.be == 4'h1 && !soft_q
        |=> cmd_q[$past(idx)][15:8] == $past(cmd_q[idx][15:8]))
        else $error("disabled lane written");
    id_ro_a: assert property (acc && !req_i.wr && req_i.dw == `CSM_DW_ID
        |=> rsp_o.rdata[15:0] == VENDOR_ID) else $error("id changed");
    cov_w1c_c: cover property (wr_acc && req_i.dw == `CSM_DW_ERRLOG);
    cov_lock_c: cover property (wr_acc && req_i.dw == `CSM_DW_LOCK
        && lkw_q[idx] != 8'h00);
    cov_off_c: cover property (claim && port_off);
    cov_set_clr_c: cover property (wr_acc && err_set_i[idx]
        && req_i.dw == `CSM_DW_ERRLOG);
endmodule
`default_nettype wire

// ==== sim/csm_host_model.sv ====
// csm_host_model: host side issuing configuration reads and writes
// assumes: bank answers one cycle after each accepted request
`default_nettype none
module csm_host_model (
    input wire logic clk_i,
    input wire logic rsp_valid_i,
    input wire csm_pkg::csm_rsp_type rsp_i,
    output logic req_valid_o,
    output csm_pkg::csm_req_type req_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle until the bench starts a transfer
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end

    // one access held for one edge; any lane mix is legal here
    task automatic access(input logic wr, input logic [7:0] bus,
        input logic [4:0] dev, input logic [2:0] fn, input logic [5:0] dw,
        input logic [3:0] be, input logic [31:0] wd,
        output csm_pkg::csm_rsp_type rsp, output logic vld);
        @(posedge clk_i);
        #1;
        req_o = '{wr, bus, dev, fn, dw, be, wd};
        req_valid_o = 1'b1;
        @(posedge clk_i);
        #1;
        req_valid_o = 1'b0;
        // released fields flip so stale values cannot pass for a request
        req_o = ~req_o;
        rsp = rsp_i;
        vld = rsp_valid_i;
    endtask

    // reserved bits kept by reading first, so only masked bits change
    task automatic merge_write(input logic [4:0] dev, input logic [2:0] fn,
        input logic [5:0] dw, input logic [31:0] mask,
        input logic [31:0] val);
        csm_pkg::csm_rsp_type r;
        logic v;
        access(1'b0, 8'h00, dev, fn, dw, 4'hf, 32'h0, r, v);
        access(1'b1, 8'h00, dev, fn, dw, 4'hf,
            (r.rdata & ~mask) | (val & mask), r, v);
    endtask
endmodule
`default_nettype wire

// ==== sim/csm_bank_tb.sv ====
// csm_bank_tb: self-checking bench for the configuration bank
// assumes: host model issues requests; resets, straps and events come here
`include "csm_map.svh"
`default_nettype none
module csm_bank_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] VID = 16'h1234; // arbitrary value
    localparam logic [15:0] DBASE = 16'h0a00; // arbitrary value
    logic clk_i, resetn_i, pwr_good, soft_reset_i, req_valid, rsp_valid, v;
    logic [7:0] strap_i, err_set_i;
    logic [2:0] port_en;
    csm_pkg::csm_req_type req;
    csm_pkg::csm_rsp_type rsp, r;
    int n_errors, tests_run, cycles;

    csm_bank #(.VENDOR_ID(VID), .DEVICE_BASE(DBASE), .STRAP_W(8)) csm_bank_i (
        .clk_i(clk_i), .resetn_i(resetn_i),
        .supply_valid_reset_in_i(pwr_good), .soft_reset_i(soft_reset_i),
        .strap_i(strap_i), .req_valid_i(req_valid), .req_i(req),
        .err_set_i(err_set_i), .rsp_valid_o(rsp_valid), .rsp_o(rsp),
        .port_en_o(port_en));
    csm_host_model csm_host_model_i (.clk_i(clk_i), .rsp_valid_i(rsp_valid),
        .rsp_i(rsp), .req_valid_o(req_valid), .req_o(req));

    // free-running clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // hang guard, far above the roughly 170 cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // every access must be answered the cycle after it is taken
    task automatic acc(input logic wr, input logic [7:0] bus,
        input logic [4:0] dev, input logic [2:0] fn, input logic [5:0] dw,
        input logic [3:0] be, input logic [31:0] wd);
        csm_host_model_i.access(wr, bus, dev, fn, dw, be, wd, r, v);
        chk({31'h0, v}, 32'h1);
    endtask

    task automatic rd(input logic [4:0] dev, input logic [2:0] fn,
        input logic [5:0] dw, input logic [31:0] exp);
        acc(1'b0, 8'h00, dev, fn, dw, 4'hf, 32'h0);
        chk(r.rdata, exp);
    endtask

    task automatic wrt(input logic [4:0] dev, input logic [2:0] fn,
        input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
        acc(1'b1, 8'h00, dev, fn, dw, be, wd);
    endtask

    task automatic flags(input logic hit, input logic abort);
        chk({30'h0, r.hit, r.abort}, {30'h0, hit, abort});
    endtask

    // reset mid-run; all selects the power-good input as well
    task automatic rst(input logic all, input logic [7:0] st);
        @(posedge clk_i);
        #1;
        resetn_i = 1'b0;
        pwr_good = !all;
        strap_i = st;
        repeat (3) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        pwr_good = 1'b1;
        repeat (5) @(posedge clk_i);
    endtask

    task automatic err_pulse;
        @(posedge clk_i);
        #1;
        err_set_i = 8'h01;
        @(posedge clk_i);
        #1;
        err_set_i = 8'h00;
    endtask

    task automatic t_map;
        logic [4:0] d;
        rd(5'd0, 3'd0, `CSM_DW_ID, {DBASE, VID});
        rd(5'd0, 3'd0, `CSM_DW_CLASS, `CSM_CLASS_HOST);
        rd(5'd0, 3'd0, `CSM_DW_HDR, `CSM_HDR_HOST);
        rd(5'd0, 3'd0, `CSM_DW_CMD, 32'h0);
        acc(1'b0, 8'h00, 5'd0, 3'd1, `CSM_DW_ID, 4'hf, 32'h0);
        flags(1'b1, 1'b0);
        for (int i = 0; i < 3; i++) begin
            d = 5'(i + 2);
            rd(d, 3'd0, `CSM_DW_CLASS, `CSM_CLASS_P2P);
            rd(d, 3'd0, `CSM_DW_HDR, `CSM_HDR_P2P);
            rd(d, 3'd1, `CSM_DW_CLASS, `CSM_CLASS_ERR);
            rd(d, 3'd1, `CSM_DW_HDR, `CSM_HDR_ERR);
        end
        // off bus 0, an absent device and a third function are not claimed
        acc(1'b1, 8'h01, 5'd0, 3'd0, `CSM_DW_CMD, 4'hf, 32'h6);
        flags(1'b0, 1'b0);
        acc(1'b0, 8'h00, 5'd1, 3'd0, `CSM_DW_ID, 4'hf, 32'h0);
        chk(r.rdata, `CSM_ALL_ONES);
        acc(1'b0, 8'h00, 5'd0, 3'd2, `CSM_DW_ID, 4'hf, 32'h0);
        flags(1'b0, 1'b0);
        rd(5'd0, 3'd0, `CSM_DW_CMD, 32'h0);
    endtask

    task automatic t_lanes;
        wrt(5'd0, 3'd0, `CSM_DW_ID, 4'hf, 32'h0);
        rd(5'd0, 3'd0, `CSM_DW_ID, {DBASE, VID});
        wrt(5'd2, 3'd0, `CSM_DW_CLASS, 4'hf, 32'h0);
        rd(5'd2, 3'd0, `CSM_DW_CLASS, `CSM_CLASS_P2P);
        csm_host_model_i.merge_write(5'd2, 3'd0, `CSM_DW_BUSNUM,
            32'h0000ff00, 32'h00000500);
        wrt(5'd2, 3'd0, `CSM_DW_BUSNUM, 4'h1, 32'hffff00aa);
        rd(5'd2, 3'd0, `CSM_DW_BUSNUM, 32'h000005aa);
        rd(5'd3, 3'd0, `CSM_DW_BUSNUM, 32'h0);
    endtask

    task automatic t_sticky;
        wrt(5'd0, 3'd0, `CSM_DW_LOCK, 4'h1, 32'h5a);
        wrt(5'd0, 3'd0, `CSM_DW_LOCK, 4'h1, 32'ha5);
        rd(5'd0, 3'd0, `CSM_DW_LOCK, 32'h5a);
        err_pulse();
        rd(5'd0, 3'd0, `CSM_DW_ERRLOG, 32'h1);
        err_pulse();
        rd(5'd0, 3'd0, `CSM_DW_ERRLOG, 32'h3);
        wrt(5'd0, 3'd0, `CSM_DW_ERRLOG, 4'hf, 32'h1);
        rd(5'd0, 3'd0, `CSM_DW_ERRLOG, 32'h2);
        wrt(5'd0, 3'd0, `CSM_DW_ERRLOG, 4'hf, 32'h0);
        rd(5'd0, 3'd0, `CSM_DW_ERRLOG, 32'h2);
        // soft reset clears command, reloads misc from the straps, keeps the log
        wrt(5'd0, 3'd0, `CSM_DW_CMD, 4'h3, 32'h6);
        rd(5'd0, 3'd0, `CSM_DW_CMD, 32'h6);
        wrt(5'd0, 3'd0, `CSM_DW_MISC, 4'h1, 32'h3c);
        rd(5'd0, 3'd0, `CSM_DW_MISC, 32'h3c);
        soft_reset_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        soft_reset_i = 1'b0;
        repeat (4) @(posedge clk_i);
        rd(5'd0, 3'd0, `CSM_DW_CMD, 32'h0);
        rd(5'd0, 3'd0, `CSM_DW_ERRLOG, 32'h2);
        rd(5'd0, 3'd0, `CSM_DW_MISC, 32'h7);
        rst(1'b0, 8'h07);
        rd(5'd0, 3'd0, `CSM_DW_ERRLOG, 32'h2);
        rd(5'd0, 3'd0, `CSM_DW_LOCK, 32'h5a);
        // event in the cycle of a clear: first bit set wins, overflow clears
        fork
            wrt(5'd0, 3'd0, `CSM_DW_ERRLOG, 4'hf, 32'h3);
            err_pulse();
        join
        rd(5'd0, 3'd0, `CSM_DW_ERRLOG, 32'h1);
    endtask

    task automatic t_power;
        rst(1'b1, 8'h05);
        rd(5'd0, 3'd0, `CSM_DW_ERRLOG, 32'h0);
        rd(5'd0, 3'd0, `CSM_DW_LOCK, 32'h0);
        chk({29'h0, port_en}, 32'h5);
        rd(5'd0, 3'd0, `CSM_DW_MISC, 32'h5);
        acc(1'b0, 8'h00, 5'd3, 3'd0, `CSM_DW_ID, 4'hf, 32'h0);
        chk(r.rdata, `CSM_ALL_ONES);
        flags(1'b0, 1'b0);
        acc(1'b1, 8'h00, 5'd3, 3'd0, `CSM_DW_CMD, 4'hf, 32'h6);
        flags(1'b0, 1'b1);
        rd(5'd4, 3'd0, `CSM_DW_CLASS, `CSM_CLASS_P2P);
        wrt(5'd0, 3'd0, `CSM_DW_LOCK, 4'h1, 32'ha5);
        rd(5'd0, 3'd0, `CSM_DW_LOCK, 32'ha5);
    endtask

    // main sequence
    initial begin
        n_errors = 0;
        tests_run = 0;
        cycles = 0;
        resetn_i = 1'b0;
        pwr_good = 1'b0;
        soft_reset_i = 1'b0;
        strap_i = 8'h07;
        err_set_i = 8'h00;
        repeat (16) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        pwr_good = 1'b1;
        repeat (5) @(posedge clk_i);
        t_map();
        t_lanes();
        t_sticky();
        t_power();
        results();
    end
endmodule
`default_nettype wire
